// ### afp_top.sv
// Chosen here: the AHB-Lite slave port and the register offsets.
`timescale 1ns/1ps
`include "afp_map.svh"
module afp_top import afp_pkg::*; #(
  parameter int RING_BYTES = `AFP_RING_BYTES,
  parameter int LEN_DEPTH = `AFP_LEN_DEPTH
) (
  input wire logic hclk, // 40 MHz bus clock
  input wire logic hresetn, // async reset, active low
  input wire logic hsel, // slave select
  input wire logic [31:0] haddr, // byte address
  input wire logic [1:0] htrans, // transfer type
  input wire logic hwrite, // write when high
  input wire logic [2:0] hsize, // word only
  input wire logic [31:0] hwdata, // write data
  input wire logic hready, // bus ready
  output logic hreadyout, // always ready
  output logic [31:0] hrdata, // read data
  output logic hresp, // always okay
  input wire logic rx_valid, // received char strobe
  input wire logic [7:0] rx_data, // received char
  input wire logic rx_break, // line break seen
  output logic tx_valid, // char offered to line
  output logic [7:0] tx_data, // char to line
  input wire logic tx_ready, // line takes char
  input wire logic cts, // partner ready, high active
  output logic rts // request to send
);
  localparam int AW = $clog2(RING_BYTES);
  localparam int LW = AW + 1;
  localparam int TW = $clog2(LEN_DEPTH);

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    return a == off;
  endfunction

  logic [7:0] ring [0:RING_BYTES-1];
  logic [LW-1:0] len_mem [0:LEN_DEPTH-1];
  logic ap_wr_ff, err_ff, ovf_ff, brk_ff;
  logic [7:0] ap_addr_ff, ctrl_ff, maxtel_ff, last_ff, tel_cnt_ff, hold_ff, tx_data_ff;
  logic [31:0] hrdata_ff;
  logic [15:0] endchr_ff, flowchr_ff, code_ff;
  logic [23:0] cdt_ff, wait_ff, cdt_cnt_ff, wait_cnt_ff;
  logic [LW-1:0] fixlen_ff, frm_len_ff, used_ff, popped_ff;
  logic [AW-1:0] rd_ptr_ff, cwr_ptr_ff;
  logic [TW-1:0] lrd_ff, lwr_ff;
  afp_prt_t prt_ff;
  logic nolf_ff, hold_v_ff, xoff_ff, xon_pend_ff, rts_ff, tx_valid_ff;

  afp_end_t mode;
  logic ap, wr, rd_ap, pop, start, clr;
  logic printing, sw_flow, acc, brk_hit, tmo, room;
  logic close, abort, store;
  logic [LW-1:0] clen, oldest, rest;
  logic full, drop, discard, do_commit, pop_ok, last_pop;
  logic paused, slot_free, load_xon, load_byte, load_lf, prt_abort;

  assign mode = afp_end_t'(ctrl_ff[1:0]);
  assign ap = hsel && htrans[1] && hready;
  assign rd_ap = ap && !hwrite;
  assign wr = ap_wr_ff;
  assign start = wr && hit(ap_addr_ff, `AFP_REG_CTRL) && hwdata[`AFP_C_START];
  // start acts on the configuration written together with it
  assign clr = start && hwdata[`AFP_C_CLR];
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_ff;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_wr_ff <= 1'b0;
      ap_addr_ff <= 8'h00;
    end else begin
      ap_wr_ff <= ap && hwrite;
      ap_addr_ff <= haddr[7:0];
    end
  end

  // configuration registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_ff <= `AFP_CTRL_RST;
      endchr_ff <= `AFP_ENDCHR_RST;
      fixlen_ff <= `AFP_FIXLEN_RST;
      cdt_ff <= `AFP_CDT_RST;
      maxtel_ff <= `AFP_MAXTEL_RST;
      flowchr_ff <= `AFP_FLOWCHR_RST;
      wait_ff <= `AFP_WAIT_RST;
    end else if (wr) begin
      if (hit(ap_addr_ff, `AFP_REG_CTRL)) ctrl_ff <= hwdata[7:0];
      if (hit(ap_addr_ff, `AFP_REG_ENDCHR)) endchr_ff <= hwdata[15:0];
      if (hit(ap_addr_ff, `AFP_REG_FIXLEN)) fixlen_ff <= hwdata[LW-1:0];
      if (hit(ap_addr_ff, `AFP_REG_CDT)) cdt_ff <= hwdata[23:0];
      if (hit(ap_addr_ff, `AFP_REG_MAXTEL)) begin
        // out-of-range limits are clamped into 1..250
        if (hwdata[7:0] == 8'h00) maxtel_ff <= 8'h01;
        else if (hwdata[7:0] > `AFP_MAX_TEL) maxtel_ff <= `AFP_MAX_TEL;
        else maxtel_ff <= hwdata[7:0];
      end
      if (hit(ap_addr_ff, `AFP_REG_FLOWCHR)) flowchr_ff <= hwdata[15:0];
      if (hit(ap_addr_ff, `AFP_REG_WAIT)) wait_ff <= hwdata[23:0];
    end
  end

  // receive framing
  assign printing = prt_ff != AFP_PRT_IDLE;
  assign sw_flow = ctrl_ff[`AFP_C_FLOW] && !ctrl_ff[`AFP_C_HW];
  assign acc = rx_valid && !printing;
  assign brk_hit = rx_break && ctrl_ff[`AFP_C_BRK];
  assign tmo = frm_len_ff != '0 && cdt_cnt_ff >= cdt_ff;
  assign room = (used_ff + frm_len_ff) < LW'(RING_BYTES);

  always_comb begin
    close = 1'b0;
    abort = 1'b0;
    store = 1'b0;
    if (clr) begin
      abort = 1'b0;
    end else if (brk_hit) begin
      abort = frm_len_ff != '0;
    end else if (acc) begin
      if (!room) begin
        abort = 1'b1;
      end else begin
        store = 1'b1;
        case (mode)
          AFP_END_CHR: begin
            if (ctrl_ff[`AFP_C_TWO])
              close = frm_len_ff != '0 && last_ff == endchr_ff[7:0]
                && rx_data == endchr_ff[15:8];
            else
              close = rx_data == endchr_ff[7:0];
          end
          AFP_END_LEN: close = frm_len_ff + 1'b1 >= fixlen_ff;
          default: close = 1'b0;
        endcase
      end
    end else if (tmo) begin
      if (mode == AFP_END_CDT) close = 1'b1;
      else abort = 1'b1;
    end
  end

  // terminator is stored like any payload byte
  assign clen = frm_len_ff + LW'(store);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      frm_len_ff <= '0;
      last_ff <= 8'h00;
      cdt_cnt_ff <= 24'h000000;
    end else begin
      if (clr || close || abort) frm_len_ff <= '0;
      else if (store) frm_len_ff <= clen;
      if (store) last_ff <= rx_data;
      if (acc) cdt_cnt_ff <= 24'h000000;
      else if (frm_len_ff != '0 && !tmo) cdt_cnt_ff <= cdt_cnt_ff + 24'h000001;
      else if (frm_len_ff == '0) cdt_cnt_ff <= 24'h000000;
    end
  end

  always_ff @(posedge hclk) begin
    if (store) ring[cwr_ptr_ff + AW'(frm_len_ff)] <= rx_data;
    if (do_commit) len_mem[lwr_ff] <= clen;
  end

  // telegram ring bookkeeping
  assign pop = rd_ap && hit(haddr[7:0], `AFP_REG_RXDATA) && tel_cnt_ff != 8'h00;
  assign oldest = len_mem[lrd_ff];
  assign rest = oldest - popped_ff;
  assign full = tel_cnt_ff >= maxtel_ff;
  assign discard = close && full && ctrl_ff[`AFP_C_PROT];
  assign drop = close && full && !ctrl_ff[`AFP_C_PROT];
  assign do_commit = close && !discard;
  // a pop colliding with a drop is lost; the dropped telegram was stale anyway
  assign pop_ok = pop && !drop;
  assign last_pop = pop_ok && popped_ff + 1'b1 == oldest;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_ptr_ff <= '0;
      cwr_ptr_ff <= '0;
      used_ff <= '0;
      popped_ff <= '0;
      lrd_ff <= '0;
      lwr_ff <= '0;
      tel_cnt_ff <= 8'h00;
    end else if (clr) begin
      rd_ptr_ff <= '0;
      cwr_ptr_ff <= '0;
      used_ff <= '0;
      popped_ff <= '0;
      lrd_ff <= '0;
      lwr_ff <= '0;
      tel_cnt_ff <= 8'h00;
    end else begin
      if (drop) rd_ptr_ff <= rd_ptr_ff + AW'(rest);
      else if (pop_ok) rd_ptr_ff <= rd_ptr_ff + 1'b1;
      if (do_commit) begin
        cwr_ptr_ff <= cwr_ptr_ff + AW'(clen);
        lwr_ff <= lwr_ff + 1'b1;
      end
      used_ff <= used_ff + (do_commit ? clen : '0)
        - (drop ? rest : LW'(pop_ok));
      if (drop || last_pop) begin
        lrd_ff <= lrd_ff + 1'b1;
        popped_ff <= '0;
      end else if (pop_ok) begin
        popped_ff <= popped_ff + 1'b1;
      end
      tel_cnt_ff <= tel_cnt_ff + 8'(do_commit) - 8'(drop || last_pop);
    end
  end

  // sticky status, set wins over write-one-to-clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      err_ff <= 1'b0;
      ovf_ff <= 1'b0;
      brk_ff <= 1'b0;
      code_ff <= 16'h0000;
    end else begin
      if (abort) err_ff <= 1'b1;
      else if (wr && hit(ap_addr_ff, `AFP_REG_STATUS) && hwdata[`AFP_S_ERR]) err_ff <= 1'b0;
      if (discard || (acc && !room)) ovf_ff <= 1'b1;
      else if (wr && hit(ap_addr_ff, `AFP_REG_STATUS) && hwdata[`AFP_S_OVF]) ovf_ff <= 1'b0;
      if (brk_hit) brk_ff <= 1'b1;
      else if (wr && hit(ap_addr_ff, `AFP_REG_STATUS) && hwdata[`AFP_S_BRK]) brk_ff <= 1'b0;
      if (prt_abort) code_ff <= `AFP_STAT_ABORT;
      else if (wr && hit(ap_addr_ff, `AFP_REG_PRINT) && hwdata[`AFP_P_GO]) code_ff <= 16'h0000;
    end
  end

  // printer output with flow control
  assign paused = !cts || (sw_flow && xoff_ff);
  assign slot_free = !tx_valid_ff || tx_ready;
  assign load_xon = slot_free && xon_pend_ff;
  assign load_byte = slot_free && !xon_pend_ff && prt_ff == AFP_PRT_RUN
    && hold_v_ff && !paused;
  assign load_lf = slot_free && !xon_pend_ff && prt_ff == AFP_PRT_LF && !paused;
  assign prt_abort = printing && paused && wait_cnt_ff >= wait_ff;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prt_ff <= AFP_PRT_IDLE;
      nolf_ff <= 1'b0;
      hold_v_ff <= 1'b0;
      hold_ff <= 8'h00;
    end else if (prt_abort) begin
      prt_ff <= AFP_PRT_IDLE;
      hold_v_ff <= 1'b0;
    end else begin
      case (prt_ff)
        AFP_PRT_IDLE: begin
          if (wr && hit(ap_addr_ff, `AFP_REG_PRINT) && hwdata[`AFP_P_GO]) begin
            prt_ff <= AFP_PRT_RUN;
            nolf_ff <= hwdata[`AFP_P_NOLF];
          end
        end
        AFP_PRT_RUN: begin
          if (load_byte) hold_v_ff <= 1'b0;
          if (wr && hit(ap_addr_ff, `AFP_REG_TXDATA) && !hold_v_ff) begin
            hold_ff <= hwdata[7:0];
            hold_v_ff <= 1'b1;
          end
          // end of message only taken once the holding byte has left
          if (wr && hit(ap_addr_ff, `AFP_REG_PRINT) && hwdata[`AFP_P_END] && !hold_v_ff)
            prt_ff <= nolf_ff ? AFP_PRT_IDLE : AFP_PRT_LF;
        end
        AFP_PRT_LF: begin
          if (load_lf) prt_ff <= AFP_PRT_IDLE;
        end
        default: prt_ff <= AFP_PRT_IDLE;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wait_cnt_ff <= 24'h000000;
    end else if (printing && paused && !prt_abort) begin
      wait_cnt_ff <= wait_cnt_ff + 24'h000001;
    end else begin
      wait_cnt_ff <= 24'h000000;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      xoff_ff <= 1'b0;
      xon_pend_ff <= 1'b0;
      rts_ff <= 1'b0;
    end else begin
      if (start && hwdata[`AFP_C_FLOW] && !hwdata[`AFP_C_HW]) xon_pend_ff <= 1'b1;
      else if (load_xon) xon_pend_ff <= 1'b0;
      rts_ff <= ctrl_ff[`AFP_C_FLOW] && ctrl_ff[`AFP_C_HW];
      if (start) xoff_ff <= 1'b0;
      else if (rx_valid && printing && sw_flow && rx_data == flowchr_ff[15:8]) xoff_ff <= 1'b1;
      else if (rx_valid && printing && sw_flow && rx_data == flowchr_ff[7:0]) xoff_ff <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_valid_ff <= 1'b0;
      tx_data_ff <= 8'h00;
    end else if (load_xon) begin
      tx_valid_ff <= 1'b1;
      tx_data_ff <= flowchr_ff[7:0];
    end else if (load_byte) begin
      tx_valid_ff <= 1'b1;
      tx_data_ff <= hold_ff;
    end else if (load_lf) begin
      tx_valid_ff <= 1'b1;
      tx_data_ff <= `AFP_LF;
    end else if (tx_ready) begin
      tx_valid_ff <= 1'b0;
    end
  end

  assign tx_valid = tx_valid_ff;
  assign tx_data = tx_data_ff;
  assign rts = rts_ff;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_ff <= 32'h00000000;
    end else if (rd_ap) begin
      case (haddr[7:0])
        `AFP_REG_CTRL: hrdata_ff <= {24'h000000, ctrl_ff};
        `AFP_REG_ENDCHR: hrdata_ff <= {16'h0000, endchr_ff};
        `AFP_REG_FIXLEN: hrdata_ff <= 32'(fixlen_ff);
        `AFP_REG_CDT: hrdata_ff <= {8'h00, cdt_ff};
        `AFP_REG_MAXTEL: hrdata_ff <= {24'h000000, maxtel_ff};
        `AFP_REG_FLOWCHR: hrdata_ff <= {16'h0000, flowchr_ff};
        `AFP_REG_WAIT: hrdata_ff <= {8'h00, wait_ff};
        `AFP_REG_STATUS: hrdata_ff <= {code_ff, 2'b00, hold_v_ff, paused, printing,
          brk_ff, ovf_ff, err_ff, tel_cnt_ff};
        `AFP_REG_RXDATA: hrdata_ff <= {24'h000000, pop ? ring[rd_ptr_ff] : 8'h00};
        `AFP_REG_RXLEN: hrdata_ff <= tel_cnt_ff != 8'h00 ? 32'(rest) : 32'h00000000;
        default: hrdata_ff <= 32'h00000000;
      endcase
    end
  end

  chk_cdt_commit: assert property (@(posedge hclk) disable iff (!hresetn)
    tmo && !acc && !brk_hit && !clr && mode == AFP_END_CDT && !full && !pop
    |=> tel_cnt_ff == $past(tel_cnt_ff) + 8'h01)
    else $error("delay gap did not commit frame");
  chk_chr_close: assert property (@(posedge hclk) disable iff (!hresetn)
    acc && room && !clr && !brk_hit && mode == AFP_END_CHR && !ctrl_ff[`AFP_C_TWO]
    && rx_data == endchr_ff[7:0] |=> frm_len_ff == '0)
    else $error("end char did not close frame");
  chk_gap_abort: assert property (@(posedge hclk) disable iff (!hresetn)
    tmo && !acc && !brk_hit && !clr && mode != AFP_END_CDT |=> err_ff && frm_len_ff == '0)
    else $error("gap did not abort fragment");
  chk_len_close: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(frm_len_ff == '0) && mode == AFP_END_LEN && !$past(abort) && !$past(clr)
    |-> $past(clen) == $past(fixlen_ff))
    else $error("fixed frame closed at wrong count");
  chk_brk_off: assert property (@(posedge hclk) disable iff (!hresetn)
    !ctrl_ff[`AFP_C_BRK] |=> !$rose(brk_ff))
    else $error("break flagged while monitoring off");
  chk_tel_limit: assert property (@(posedge hclk) disable iff (!hresetn)
    tel_cnt_ff >= maxtel_ff |=> tel_cnt_ff <= $past(tel_cnt_ff))
    else $error("telegram count passed limit");
  chk_protect: assert property (@(posedge hclk) disable iff (!hresetn)
    discard && !pop |=> lrd_ff == $past(lrd_ff) && tel_cnt_ff == $past(tel_cnt_ff))
    else $error("protected telegram was overwritten");
  chk_print_drop: assert property (@(posedge hclk) disable iff (!hresetn)
    printing && frm_len_ff == '0 |=> frm_len_ff == '0)
    else $error("char stored during printout");
  chk_pause_hold: assert property (@(posedge hclk) disable iff (!hresetn)
    paused && !tx_valid && !xon_pend_ff |=> !tx_valid)
    else $error("output while paused");
  chk_wait_abort: assert property (@(posedge hclk) disable iff (!hresetn)
    prt_abort |=> prt_ff == AFP_PRT_IDLE && code_ff == `AFP_STAT_ABORT)
    else $error("wait timeout did not abort print");
endmodule

// ### afp_map.svh
`ifndef AFP_MAP_SVH
`define AFP_MAP_SVH
`define AFP_REG_CTRL 8'h00
`define AFP_REG_ENDCHR 8'h04
`define AFP_REG_FIXLEN 8'h08
`define AFP_REG_CDT 8'h0c
`define AFP_REG_MAXTEL 8'h10
`define AFP_REG_FLOWCHR 8'h14
`define AFP_REG_WAIT 8'h18
`define AFP_REG_STATUS 8'h1c
`define AFP_REG_RXDATA 8'h20
`define AFP_REG_RXLEN 8'h24
`define AFP_REG_TXDATA 8'h28
`define AFP_REG_PRINT 8'h2c
`define AFP_C_TWO 2
`define AFP_C_BRK 3
`define AFP_C_PROT 4
`define AFP_C_CLR 5
`define AFP_C_HW 6
`define AFP_C_FLOW 7
`define AFP_C_START 8
`define AFP_S_ERR 8
`define AFP_S_OVF 9
`define AFP_S_BRK 10
`define AFP_S_BUSY 11
`define AFP_S_PAUSE 12
`define AFP_S_HOLD 13
`define AFP_P_GO 0
`define AFP_P_NOLF 1
`define AFP_P_END 2
`define AFP_CTRL_RST 8'h08
`define AFP_ENDCHR_RST 16'h0a0d
`define AFP_FIXLEN_RST 11'h010
`define AFP_CDT_RST 24'h000fa0
`define AFP_MAXTEL_RST 8'hfa
`define AFP_FLOWCHR_RST 16'h1311
`define AFP_WAIT_RST 24'h009c40
`define AFP_LF 8'h0a
`define AFP_STAT_ABORT 16'h0708
`define AFP_RING_BYTES 1024
`define AFP_MAX_TEL 8'hfa
`define AFP_LEN_DEPTH 256
`endif

// ### afp_pkg.sv
package afp_pkg;
  typedef enum logic [1:0] {
    AFP_END_CDT = 2'b00,
    AFP_END_CHR = 2'b01,
    AFP_END_LEN = 2'b10
  } afp_end_t;
  typedef enum logic [1:0] {
    AFP_PRT_IDLE = 2'b00,
    AFP_PRT_RUN = 2'b01,
    AFP_PRT_LF = 2'b10
  } afp_prt_t;
endpackage

// ### afp_line_model.sv
`timescale 1ns/1ps
module afp_line_model (
  input wire logic hclk, // bench clock
  input wire logic tx_valid, // char offered by block
  input wire logic [7:0] tx_data, // char from block
  input wire logic rts, // block request to send
  output logic rx_valid, // char strobe to block
  output logic [7:0] rx_data, // char to block
  output logic rx_break, // line break
  output logic tx_ready, // printer takes char
  output logic cts // printer ready
);
  logic slow = 1'b0;
  logic ready_lvl = 1'b1;
  logic tgl = 1'b0;
  logic [7:0] got[$];
  initial begin
    rx_valid = 1'b0;
    rx_data = 8'h00;
    rx_break = 1'b0;
  end
  // printer shows readiness on cts only
  assign cts = ready_lvl;
  // a slow printer takes a char every other cycle
  assign tx_ready = ~slow | tgl;
  always @(posedge hclk) begin
    tgl <= ~tgl;
    if (tx_valid && tx_ready) begin
      got.push_back(tx_data);
    end
  end
  // callers keep 11h/13h out of payload while flow control runs
  task automatic send(input logic [7:0] b, input int gap);
    @(posedge hclk);
    rx_valid <= 1'b1;
    rx_data <= b;
    @(posedge hclk);
    rx_valid <= 1'b0;
    // idle line must not keep showing the last char
    rx_data <= ~b;
    repeat (gap) @(posedge hclk);
  endtask
  task automatic brk();
    @(posedge hclk);
    rx_break <= 1'b1;
    @(posedge hclk);
    rx_break <= 1'b0;
  endtask
endmodule

// ### afp_top_tb.sv
`timescale 1ns/1ps
`include "afp_map.svh"
module afp_top_tb;
  localparam logic [7:0] CT = `AFP_REG_CTRL, FL = `AFP_REG_FIXLEN, CD = `AFP_REG_CDT;
  localparam logic [7:0] MT = `AFP_REG_MAXTEL, FC = `AFP_REG_FLOWCHR, WT = `AFP_REG_WAIT;
  localparam logic [7:0] ST = `AFP_REG_STATUS, RX = `AFP_REG_RXDATA, RL = `AFP_REG_RXLEN;
  localparam logic [7:0] TX = `AFP_REG_TXDATA, PR = `AFP_REG_PRINT;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic rx_valid, rx_break, tx_valid, tx_ready, cts, rts;
  logic [7:0] rx_data, tx_data;
  int n_mismatch = 0;
  int checked = 0;

  afp_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .rx_valid(rx_valid),
    .rx_data(rx_data), .rx_break(rx_break), .tx_valid(tx_valid), .tx_data(tx_data),
    .tx_ready(tx_ready), .cts(cts), .rts(rts));
  afp_line_model line (.hclk(hclk), .tx_valid(tx_valid), .tx_data(tx_data), .rts(rts),
    .rx_valid(rx_valid), .rx_data(rx_data), .rx_break(rx_break), .tx_ready(tx_ready),
    .cts(cts));

  initial begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end

  task automatic print_verdict();
    $display("checked %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h000000, a};
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  // masked read compare; masks skip fields this bench cannot predict
  task automatic rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
                    input string nm);
    bus(1'b0, a, 32'h00000000);
    chk(nm, e, rd & m);
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge hclk);
  endtask

  task automatic tel(input logic [7:0] b, input int n, input int gap);
    for (int i = 0; i < n; i++) begin
      line.send(b + 8'(i), gap);
    end
  endtask

  task automatic drain(input logic [7:0] b, input int n);
    rc(RL, 32'hffff, n, "rxlen");
    for (int i = 0; i < n; i++) begin
      rc(RX, 32'hff, {24'h000000, b + 8'(i)}, "rxdata");
    end
  endtask

  task automatic pair();
    tel(8'ha0, 2, 1);
    idle(40);
    tel(8'hb0, 3, 1);
    idle(40);
  endtask

  task automatic txc(input logic [7:0] e);
    int k = 0;
    while (line.got.size() == 0 && k < 200) begin
      @(posedge hclk);
      k++;
    end
    chk("tx", {24'h000000, e},
        (line.got.size() > 0) ? {24'h000000, line.got.pop_front()} : 32'hffffffff);
  endtask

  initial begin
    repeat (20000) @(posedge hclk);
    n_mismatch++;
    print_verdict();
  end

  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h00000000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h00000000;
    idle(2);
    hresetn <= 1'b1;
    rc(CT, 32'h1ff, 32'h008, "ctrl");
    chk("hresp", 32'h0, {31'h0, hresp});
    rc(FC, 32'hffff, 32'h1311, "flowchr");
    rc(MT, 32'hff, 32'hfa, "maxtel");
    wr(8'h30, 32'hffffffff);
    rc(8'h30, 32'hffffffff, 32'h0, "unmapped");
    wr(MT, 32'h0);
    rc(MT, 32'hff, 32'h01, "maxtel low");
    wr(MT, 32'hfb);
    rc(MT, 32'hff, 32'hfa, "maxtel high");
    wr(CD, 32'd20);
    wr(WT, 32'd50);
    // gaps of 12 cycles keep one 36 cycle frame open
    tel(8'h40, 3, 10);
    idle(40);
    rc(ST, 32'h1ff, 32'h001, "gap close");
    drain(8'h40, 3);
    wr(CT, 32'h009);
    line.send(8'h41, 1);
    line.send(8'h42, 1);
    line.send(8'h0d, 0);
    rc(ST, 32'h1ff, 32'h001, "end char");
    rc(RL, 32'hffff, 32'h3, "rxlen");
    rc(RX, 32'hff, 32'h41, "rxdata");
    rc(RX, 32'hff, 32'h42, "rxdata");
    rc(RX, 32'hff, 32'h0d, "rxdata");
    line.send(8'h41, 40);
    rc(ST, 32'h1ff, 32'h100, "end char gap");
    wr(ST, 32'h700);
    wr(FL, 32'h4);
    wr(CT, 32'h00a);
    tel(8'h50, 4, 0);
    rc(ST, 32'h1ff, 32'h001, "fixed");
    drain(8'h50, 4);
    tel(8'h60, 2, 1);
    idle(40);
    rc(ST, 32'h1ff, 32'h100, "fixed gap");
    wr(ST, 32'h700);
    wr(CT, 32'h000);
    line.send(8'h70, 1);
    line.brk();
    idle(40);
    rc(ST, 32'h4ff, 32'h001, "break off");
    drain(8'h70, 1);
    wr(CT, 32'h008);
    line.send(8'h71, 1);
    line.brk();
    idle(40);
    rc(ST, 32'h4ff, 32'h400, "break on");
    wr(ST, 32'h700);
    pair();
    rc(ST, 32'hff, 32'h2, "two queued");
    drain(8'ha0, 2);
    drain(8'hb0, 3);
    wr(MT, 32'h1);
    pair();
    rc(ST, 32'hff, 32'h1, "limit one");
    drain(8'hb0, 3);
    wr(CT, 32'h018);
    pair();
    rc(ST, 32'h2ff, 32'h201, "protected");
    drain(8'ha0, 2);
    wr(ST, 32'h700);
    wr(MT, 32'hfa);
    wr(CT, 32'h008);
    pair();
    wr(CT, 32'h128);
    rc(ST, 32'hff, 32'h0, "start clear");
    tel(8'h00, 1024, 0);
    idle(40);
    rc(ST, 32'h3ff, 32'h001, "ring full");
    rc(RL, 32'hffff, 32'd1024, "ring len");
    line.send(8'h05, 40);
    rc(ST, 32'h3ff, 32'h301, "ring over");
    wr(CT, 32'h128);
    wr(ST, 32'h700);
    wr(CT, 32'h188);
    txc(8'h11);
    wr(PR, 32'h1);
    wr(TX, 32'h41);
    txc(8'h41);
    line.send(8'h5a, 1);
    line.send(8'h13, 2);
    rc(ST, 32'h18ff, 32'h1800, "pause char");
    idle(80);
    rc(ST, 32'hffff08ff, 32'h07080000, "abort");
    line.ready_lvl <= 1'b0;
    wr(CT, 32'h1c8);
    wr(PR, 32'h1);
    chk("rts", 32'h1, {31'h0, rts});
    wr(TX, 32'h43);
    idle(10);
    rc(ST, 32'h1800, 32'h1800, "cts low");
    chk("held", 32'h0, line.got.size());
    line.ready_lvl <= 1'b1;
    line.slow <= 1'b1;
    txc(8'h43);
    wr(PR, 32'h4);
    txc(8'h0a);
    idle(10);
    rc(ST, 32'h800, 32'h0, "print done");
    wr(PR, 32'h3);
    wr(TX, 32'h44);
    txc(8'h44);
    wr(PR, 32'h4);
    idle(20);
    chk("no lf", 32'h0, line.got.size());
    print_verdict();
  end
endmodule
